/* common/host_link_pkg.sv */
/*
 types for the host link control register.
 assumes the constants header sits beside it.
*/
`include "host_link_regs.svh"
package host_link_pkg;
   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_ADDR = 2'b01,
      SPI_DATA = 2'b10
   } spi_phase_t;

   typedef logic [7:0] ctrl_byte_t;
endpackage

/* common/host_link_regs.svh */
/*
 host link control register: offsets, field positions, reset value
 and timing figures. assumes inclusion by the package and the rtl.
*/
// Notes on behaviour
// - bits 0-3 halt one host channel each
// - halt clears channel staging buffer, partial sample
// - halt drops status; data kept, re-requested later
// - halt ends session only; purge needs command
// - bit 4 asleep: only wake-up events interrupt
// - bit 6 picks latched timestamp, resets zero
// - request-time capture suppresses request timestamp packet
// - mode bit: channel 3 sync clear, async set
// - host irq holds until pending queues handled
// - halt bits never self-clear
// - halt loses 32 bytes in short cases
// - offset 0x06 readable and writable; bit 5 reserved
// - status queue mode sits in bit 7
// - channel 0 command in, 1-3 outputs
`ifndef HOST_LINK_REGS_SVH
`define HOST_LINK_REGS_SVH

`define HLC_OFFSET      7'h06
`define HLC_RESET       8'h00
`define HLC_HALT_LSB    0
`define HLC_ASLEEP_BIT  4
`define HLC_RSVD_BIT    5
`define HLC_TS_SEL_BIT  6
`define HLC_ASYNC_BIT   7
`define HLC_WR_MASK     8'hdf
`define XFER_BYTES      6'h20
`define HALT_SETTLE_MS  2
`define SPI_ADDR_BITS   4'h8
`define SPI_LAST_BIT    4'hf

`endif

/* rtl/host_link_control_register.sv */
/*
 host link control register with its channel, interrupt and
 timestamp effects, reached over the spi host port (mode 0,
 first byte = read flag + 7-bit address, second byte = data).
 assumes queue and event inputs come from logic on sys_clk.
*/
`timescale 1ns/1ns
`include "host_link_regs.svh"
module host_link_control_register
   import host_link_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sck,
   input  wire logic        spi_mosi,
   output logic             spi_miso_out,
   output logic             spi_miso_oe_n,
   input  wire logic [3:0]  ch_pending,
   input  wire logic [3:0]  ch_short_xfer,
   input  wire logic [3:0]  ch_last_block,
   input  wire logic        wake_evt,
   input  wire logic        nonwake_evt,
   input  wire logic        irq_enable,
   input  wire logic        ts_req_write,
   input  wire logic [39:0] time_now,
   output logic [3:0]       ch_halt,
   output logic [3:0]       ch_buf_clear,
   output logic [3:0]       ch_data_lost,
   output logic [3:0]       ch_status,
   output logic             host_irq,
   output logic [39:0]      irq_timestamp,
   output logic             ts_packet_emit,
   output logic             status_async
);
   logic [2:0]  sck_sync_reg;
   logic [1:0]  cs_sync_reg;
   logic [1:0]  mosi_sync_reg;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_act;
   spi_phase_t  phase_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  rx_reg;
   logic        rd_reg;
   logic [6:0]  addr_reg;
   logic [7:0]  tx_reg;
   ctrl_byte_t  ctrl_reg;
   ctrl_byte_t  ctrl_next;
   logic        ctrl_wr;
   logic [3:0]  halt_prev_reg;
   logic        irq_set;
   logic        irq_clear;

   // pins cross in through two flops; sck edges compare the second flop with a third
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_sync_reg  <= 3'h0;
         cs_sync_reg   <= 2'h3;
         mosi_sync_reg <= 2'h0;
      end else begin
         sck_sync_reg  <= {sck_sync_reg[1:0], spi_sck};
         cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n};
         mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      end
   end

   assign cs_act   = ~cs_sync_reg[1];
   assign sck_rise = cs_act & sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = cs_act & ~sck_sync_reg[1] & sck_sync_reg[2];

   function automatic ctrl_byte_t read_value(input logic [6:0] a,
                                             input ctrl_byte_t r);
      read_value = (a == `HLC_OFFSET) ? r : 8'h00;
   endfunction

   // serial framing
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg   <= SPI_IDLE;
         bit_cnt_reg <= 4'h0;
         rx_reg      <= 8'h00;
         rd_reg      <= 1'b0;
         addr_reg    <= 7'h00;
      end else if (!cs_act) begin
         phase_reg   <= SPI_IDLE;
         bit_cnt_reg <= 4'h0;
      end else if (sck_rise) begin
         rx_reg      <= {rx_reg[6:0], mosi_sync_reg[1]};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         case (phase_reg)
            SPI_IDLE: begin
               phase_reg <= SPI_ADDR;
            end
            SPI_ADDR: begin
               if (bit_cnt_reg == `SPI_ADDR_BITS - 4'h1) begin
                  rd_reg    <= rx_reg[6];
                  addr_reg  <= {rx_reg[5:0], mosi_sync_reg[1]};
                  phase_reg <= SPI_DATA;
               end
            end
            SPI_DATA: begin
               // further bytes start a new command byte; single-register port
               if (bit_cnt_reg == `SPI_LAST_BIT)
                  phase_reg <= SPI_IDLE;
            end
            default: begin
               phase_reg <= SPI_IDLE;
            end
         endcase
      end
   end

   // read data shifts out on falling edges after the address
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_reg        <= 8'h00;
         spi_miso_out  <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else if (!cs_act) begin
         spi_miso_oe_n <= 1'b1;
      end else if (sck_rise && phase_reg == SPI_ADDR &&
                   bit_cnt_reg == `SPI_ADDR_BITS - 4'h1) begin
         tx_reg <= read_value({rx_reg[5:0], mosi_sync_reg[1]}, ctrl_reg);
      end else if (sck_fall && phase_reg == SPI_DATA && rd_reg) begin
         spi_miso_out  <= tx_reg[7];
         spi_miso_oe_n <= 1'b0;
         tx_reg        <= {tx_reg[6:0], 1'b0};
      end
   end

   assign ctrl_wr = sck_rise && phase_reg == SPI_DATA && !rd_reg &&
                    bit_cnt_reg == `SPI_LAST_BIT && addr_reg == `HLC_OFFSET;
   assign ctrl_next = {rx_reg[6:0], mosi_sync_reg[1]} & `HLC_WR_MASK;

   // halt bits hold whatever the host last wrote
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         ctrl_reg <= `HLC_RESET;
      else if (ctrl_wr)
         ctrl_reg <= ctrl_next;
   end

   // channel effects; buffer clear pulses on each rising halt edge, loss pulse on those with a short or last-block transfer
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         halt_prev_reg <= 4'h0;
         ch_halt       <= 4'h0;
         ch_buf_clear  <= 4'h0;
         ch_data_lost  <= 4'h0;
         ch_status     <= 4'h0;
      end else begin
         halt_prev_reg <= ctrl_reg[3:0];
         ch_halt       <= ctrl_reg[3:0];
         ch_buf_clear  <= ctrl_reg[3:0] & ~halt_prev_reg;
         // short transfer or exactly one 32-byte block left
         ch_data_lost  <= ctrl_reg[3:0] & ~halt_prev_reg &
                          (ch_short_xfer | ch_last_block);
         // pending data stays queued and re-requests once unhalted
         ch_status     <= ch_pending & ~ctrl_reg[3:0];
      end
   end

   assign irq_set = irq_enable &
                    (wake_evt | (nonwake_evt & ~ctrl_reg[`HLC_ASLEEP_BIT]));
   assign irq_clear = &(~ch_pending | ctrl_reg[3:0]);

   // set wins over a clear landing in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         host_irq <= 1'b0;
      else if (irq_set)
         host_irq <= 1'b1;
      else if (irq_clear)
         host_irq <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_timestamp  <= 40'h0;
         ts_packet_emit <= 1'b0;
      end else begin
         if (ctrl_reg[`HLC_TS_SEL_BIT] ? ts_req_write
                                       : (irq_set && !host_irq))
            irq_timestamp <= time_now;
         ts_packet_emit <= ts_req_write &
                           ~ctrl_reg[`HLC_TS_SEL_BIT];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst)
         status_async <= 1'b0;
      else
         status_async <= ctrl_reg[`HLC_ASYNC_BIT];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_rsvd_reads_zero: assert property (!ctrl_reg[`HLC_RSVD_BIT])
      else $error("reserved bit set");
   a_halt_held: assert property (!ctrl_wr |=> $stable(ctrl_reg))
      else $error("control changed without write");
   a_wr_stores: assert property
      (ctrl_wr |=> ctrl_reg == $past(ctrl_next))
      else $error("write not stored");
   a_halt_clears_buf: assert property
      ($rose(ctrl_reg[0]) |=> ch_buf_clear[0])
      else $error("buffer clear missing");
   a_status_off: assert property
      (ctrl_reg[1] |=> !ch_status[1])
      else $error("status shown on halted channel");
   a_asleep_gates: assert property
      (ctrl_reg[`HLC_ASLEEP_BIT] && !wake_evt && !host_irq
       |=> !host_irq)
      else $error("non-wake event woke host");
   a_irq_holds: assert property
      (host_irq && !irq_clear |=> host_irq)
      else $error("irq dropped with queue pending");
   a_no_ts_packet: assert property
      (ctrl_reg[`HLC_TS_SEL_BIT] |=> !ts_packet_emit)
      else $error("request packet emitted in capture mode");
   a_ts_req_latch: assert property
      (ctrl_reg[`HLC_TS_SEL_BIT] && ts_req_write
       |=> irq_timestamp == $past(time_now))
      else $error("request time not latched");
   a_mode_follows: assert property
      (##1 status_async == $past(ctrl_reg[`HLC_ASYNC_BIT]))
      else $error("queue mode mismatch");
   a_loss_flag: assert property
      ($rose(ctrl_reg[2]) && ch_short_xfer[2] |=> ch_data_lost[2])
      else $error("data loss not flagged");

   c_write: cover property (ctrl_wr);
   c_halt_release: cover property (ctrl_reg[0] ##[1:20] !ctrl_reg[0]);
   c_irq_cycle: cover property (host_irq ##1 !host_irq);
   c_read: cover property (!spi_miso_oe_n);
endmodule

/* verif/host_link_control_register_bench.sv */
/*
 self-checking bench for the host link control register.
 assumes the package and the spi host model are compiled first.
*/
`timescale 1ns/1ns
module host_link_control_register_bench;
   import host_link_pkg::*;
   logic        sys_clk, sys_rst, spi_cs_n, spi_sck, spi_mosi;
   logic        spi_miso_out, spi_miso_oe_n, rd_strobe, host_irq;
   logic        wake_evt, nonwake_evt, irq_enable, ts_req_write;
   logic        ts_packet_emit, status_async;
   logic [3:0]  ch_pending, ch_short_xfer, ch_last_block, ch_halt;
   logic [3:0]  ch_buf_clear, ch_data_lost, ch_status, seen_clr;
   logic [3:0]  seen_lost, pkt_count;
   logic [7:0]  rd_byte;
   logic [39:0] time_now, irq_timestamp, t;
   ctrl_byte_t  v;
   ctrl_byte_t  expq[$];
   int          err_count, samples_checked;

   host_link_control_register u_dut (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .spi_cs_n       (spi_cs_n),
      .spi_sck        (spi_sck),
      .spi_mosi       (spi_mosi),
      .spi_miso_out   (spi_miso_out),
      .spi_miso_oe_n  (spi_miso_oe_n),
      .ch_pending     (ch_pending),
      .ch_short_xfer  (ch_short_xfer),
      .ch_last_block  (ch_last_block),
      .wake_evt       (wake_evt),
      .nonwake_evt    (nonwake_evt),
      .irq_enable     (irq_enable),
      .ts_req_write   (ts_req_write),
      .time_now       (time_now),
      .ch_halt        (ch_halt),
      .ch_buf_clear   (ch_buf_clear),
      .ch_data_lost   (ch_data_lost),
      .ch_status      (ch_status),
      .host_irq       (host_irq),
      .irq_timestamp  (irq_timestamp),
      .ts_packet_emit (ts_packet_emit),
      .status_async   (status_async)
   );
   spi_host_model u_host (
      .sys_clk        (sys_clk),
      .spi_cs_n       (spi_cs_n),
      .spi_sck        (spi_sck),
      .spi_mosi       (spi_mosi),
      .spi_miso_out   (spi_miso_out),
      .spi_miso_oe_n  (spi_miso_oe_n),
      .rd_strobe      (rd_strobe),
      .rd_byte        (rd_byte)
   );

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input ctrl_byte_t d);
      u_host.xfer({1'b0, a}, d);
   endtask
   task automatic rd(input logic [6:0] a, input ctrl_byte_t e);
      expq.push_back(e);
      u_host.xfer({1'b1, a}, 8'h00);
   endtask
   // one-cycle pulse; t is the time the design sees with it
   task automatic pulse(input logic [2:0] p);
      @(posedge sys_clk);
      t = time_now + 40'h1;
      {ts_req_write, nonwake_evt, wake_evt} <= p;
      @(posedge sys_clk);
      {ts_req_write, nonwake_evt, wake_evt} <= 3'b000;
      repeat (3) @(posedge sys_clk);
   endtask

   // one process owns these monitors, cleared while reset stands
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         time_now <= 40'h0;
         seen_clr <= 4'h0;
         seen_lost <= 4'h0;
         pkt_count <= 4'h0;
      end else begin
         time_now <= time_now + 40'h1;
         seen_clr <= seen_clr | ch_buf_clear;
         seen_lost <= seen_lost | ch_data_lost;
         pkt_count <= pkt_count + {3'h0, ts_packet_emit};
      end
      if (rd_strobe === 1'b1) begin
         if (expq.size() > 0)
            check(rd_byte, expq.pop_front());
         else
            err_count++;
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      test_done();
   end
   initial begin
      sys_rst = 1'b1;
      {wake_evt, nonwake_evt, irq_enable, ts_req_write} = 4'h0;
      {ch_pending, ch_short_xfer, ch_last_block} = 12'h000;
      err_count = 0;
      samples_checked = 0;
      void'($urandom(40686));
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({spi_miso_oe_n, host_irq, ch_halt, ch_status}, 40'h200);
      rd(7'h06, 8'h00);
      // halt bits stay clear: a slow host may not drop them early
      for (int i = 0; i < 4; i++) begin
         v = ctrl_byte_t'($urandom()) & 8'hf0;
         ch_pending <= 4'($urandom());
         wr(7'h06, v);
         rd(7'h06, v & 8'hdf);
         check(status_async, v[7]);
         check(ch_status, ch_pending);
      end
      wr(7'h05, 8'hff);
      rd(7'h05, 8'h00);
      rd(7'h06, v & 8'hdf);
      ch_pending <= 4'h0;
      irq_enable <= 1'b1;
      wr(7'h06, 8'h10);
      pulse(3'b010);
      check(host_irq, 1'b0);
      ch_pending <= 4'hc;
      pulse(3'b001);
      check(host_irq, 1'b1);
      check(irq_timestamp, t);
      pulse(3'b100);
      check(pkt_count, 4'h1);
      wr(7'h06, 8'h50);
      pulse(3'b100);
      check(irq_timestamp, t);
      check(pkt_count, 4'h1);
      // channel 2 always short, so its halt must report a loss
      ch_short_xfer <= 4'($urandom()) | 4'h4;
      ch_last_block <= 4'($urandom());
      wr(7'h06, 8'h53);
      check(seen_clr, 4'h3);
      check(seen_lost, (ch_short_xfer | ch_last_block) & 4'h3);
      check(ch_status, 4'hc);
      check(host_irq, 1'b1);
      wr(7'h06, 8'h5f);
      check(host_irq, 1'b0);
      check(seen_clr, 4'hf);
      check(seen_lost, ch_short_xfer | ch_last_block);
      rd(7'h06, 8'h5f);
      check(ch_halt, 4'hf);
      check(expq.size(), 40'h0);
      test_done();
   end
endmodule

/* verif/spi_host_model.sv */
/*
 spi host model: mode 0, command byte then data byte, msb first.
 assumes each call starts on a sys_clk edge; sck period 125 ns,
 free of sys_clk, so the design's synchroniser sees a true async pin.
*/
`timescale 1ns/1ns
module spi_host_model (
   input  wire logic       sys_clk,
   output logic            spi_cs_n,
   output logic            spi_sck,
   output logic            spi_mosi,
   input  wire logic       spi_miso_out,
   input  wire logic       spi_miso_oe_n,
   output logic            rd_strobe,
   output logic [7:0]      rd_byte
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
      rd_strobe = 1'b0;
      rd_byte = 8'h00;
   end
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat);
      logic [15:0] sh;
      logic [7:0]  rx;
      sh = {cmd, dat};
      rx = 8'h00;
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #62;
         spi_mosi <= sh[i];
         spi_sck <= 1'b0;
         #63;
         spi_sck <= 1'b1;
         // undriven miso reads as garbage, never as a lucky match
         rx = {rx[6:0], spi_miso_oe_n ? ~rx[0] : spi_miso_out};
      end
      #62;
      spi_sck <= 1'b0;
      spi_mosi <= ~spi_mosi;
      repeat (4) @(posedge sys_clk);
      spi_cs_n <= 1'b1;
      rd_byte <= rx;
      rd_strobe <= cmd[7];
      @(posedge sys_clk);
      rd_strobe <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule
